// *** hdl/pfs_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfs_sequencer
	import pfs_pkg::*;
#(
	parameter int unsigned OVERCURRENT_QUALIFY_CYC = OVERCURRENT_QUALIFY_DELAY_CYC,
	parameter int unsigned RESTART_CYC             = RESTART_TIME_CYC
) (
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire pfs_sense_t             sense,
	input  wire logic [FAULT_COUNT-1:0] fault_latch_cfg,
	input  wire logic                   variant_constant_current,
	input  wire logic [2:0]             profile_index,
	input  wire logic                   contract_done,
	output pfs_drive_t                  drive,
	output logic                        constant_current_regulation,
	output pfs_state_t                  seq_state,
	output logic [FAULT_COUNT-1:0]      fault_cause
);

	// Qualifying delay for each fault
	function automatic int unsigned fault_delay(input int unsigned idx);
		case (idx)
			F_OVERVOLT: fault_delay = OVERVOLTAGE_BLANKING_CYC;
			F_OVERCUR:  fault_delay = OVERCURRENT_QUALIFY_CYC;
			default:    fault_delay = 0;
		endcase
	endfunction

	logic                   rst_meta;
	logic                   rst_sync;
	logic                   core_rst_n;
	pfs_state_t             state;
	pfs_state_t             next_state;
	logic [31:0]            restart_count;
	logic                   restart_done;
	logic [FAULT_COUNT-1:0] raw_fault;
	logic [FAULT_COUNT-1:0] qual_fault;
	logic [FAULT_COUNT-1:0] latch_sel;
	logic                   any_fault;
	logic                   latch_fault;
	logic                   undervolt_enabled;
	logic                   over_limit_cc;
	logic                   load_req;
	logic                   supply_rise_d;
	logic                   supply_rise_edge;
	logic                   sink_pulse;
	pfs_drive_t             next_drive;
	pfs_drive_t             drive_reg;

	// Reset release through two flip-flops
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Core reset follows the synchronized reset only, whatever the supply level
	assign core_rst_n = rst_sync;

	// Current limit routing by variant setting
	assign over_limit_cc = sense.over_current_limit & variant_constant_current;

	// Undervoltage guard only above the second profile
	assign undervolt_enabled = (profile_index != DEFAULT_5V_PROFILE) &&
		(profile_index != SECOND_PROFILE);

	// Raw fault conditions
	assign raw_fault[F_LOCKOUT]   = sense.supply_below_fall;
	assign raw_fault[F_OVERVOLT]  = sense.overvoltage;
	assign raw_fault[F_UNDERVOLT] = sense.undervoltage & undervolt_enabled;
	assign raw_fault[F_OVERCUR]   = sense.over_current_limit & ~variant_constant_current;
	assign raw_fault[F_OVERTEMP]  = sense.over_temp;

	// Per-fault qualification and response selection
	genvar gi;
	generate
		for (gi = 0; gi < FAULT_COUNT; gi++) begin : g_fault
			pfs_qualifier #(
				.DELAY (fault_delay(gi))
			) u_qual (
				.mclk      (mclk),
				.rst_n     (core_rst_n),
				.cond      (raw_fault[gi]),
				.qualified (qual_fault[gi])
			);
			if (gi == F_OVERTEMP) begin : g_forced
				assign latch_sel[gi] = 1'b1;
			end else begin : g_cfg
				assign latch_sel[gi] = fault_latch_cfg[gi];
			end
		end
	endgenerate

	// Fault summary seen by the sequencer
	assign any_fault   = |qual_fault;
	assign latch_fault = |(qual_fault & latch_sel);

	// Restart time reached
	assign restart_done = (restart_count == 32'(RESTART_CYC - 1));

	// Rising supply edge for the latched sink
	assign supply_rise_edge = sense.supply_above_rise & ~supply_rise_d;

	// Next sequencer state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_LOCKOUT: begin
				if (sense.supply_above_rise) begin
					next_state = ST_STARTUP;
				end
			end
			ST_STARTUP, ST_RUN: begin
				if (latch_fault) begin
					next_state = ST_LATCHED;
				end else if (any_fault) begin
					next_state = ST_RESTART;
				end else if (state == ST_STARTUP && contract_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RESTART: begin
				if (latch_fault) begin
					next_state = ST_LATCHED;
				end else if (restart_done) begin
					next_state = ST_STARTUP;
				end
			end
			ST_LATCHED: begin
				next_state = ST_LATCHED;
			end
			default: begin
				next_state = ST_LOCKOUT;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			state <= ST_LOCKOUT;
		end else begin
			state <= next_state;
		end
	end

	// Restart timer runs only with supply above lockout
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			restart_count <= TIMER_RESET;
		end else if (state != ST_RESTART || !sense.supply_above_rise) begin
			restart_count <= TIMER_RESET;
		end else if (!restart_done) begin
			restart_count <= restart_count + 32'h00000001;
		end
	end

	// Cause of the last protection event
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			fault_cause <= FAULT_CAUSE_RESET;
		end else if ((state == ST_STARTUP || state == ST_RUN) && any_fault) begin
			fault_cause <= qual_fault;
		end
	end

	// Supply edge tracker and latched sink pulse stretch
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			supply_rise_d <= 1'b0;
			sink_pulse    <= 1'b0;
		end else begin
			supply_rise_d <= sense.supply_above_rise;
			sink_pulse    <= (state == ST_LATCHED) & supply_rise_edge;
		end
	end

	// Drive levels for the next cycle
	always_comb begin
		next_drive = '0;
		unique case (next_state)
			ST_STARTUP: begin
				next_drive.load_switch     = 1'b1;
				next_drive.regulate_safe5v = 1'b1;
			end
			ST_RUN: begin
				next_drive.load_switch      = 1'b1;
				next_drive.regulate_profile = 1'b1;
				next_drive.coupler_hold     = over_limit_cc;
			end
			ST_RESTART: begin
				next_drive.regulate_safe5v = sense.supply_above_rise;
				next_drive.profile_default = 1'b1;
			end
			ST_LATCHED: begin
				next_drive.current_sink = 1'b1;
				next_drive.coupler_zero = 1'b1;
			end
			default: begin
				next_drive = '0;
			end
		endcase
	end

	// Drive register
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= next_drive;
		end
	end

	// Switch request cut at once by lockout or supply loss
	assign load_req = drive_reg.load_switch & ~sense.supply_below_fall & ~sense.supply_lost;

	// Outputs towards the power stage
	always_comb begin
		drive              = drive_reg;
		drive.load_switch  = load_req;
		drive.current_sink = drive_reg.current_sink | sink_pulse;
	end

	assign constant_current_regulation = drive_reg.coupler_hold;
	assign seq_state                   = state;

endmodule
`default_nettype wire

// *** inc/pfs_pkg.sv ***
`default_nettype none
package pfs_pkg;

	// Clock rate
	localparam int unsigned CLK_HZ = 100_000_000;

	// Interval figures in their own units
	localparam int unsigned OVERVOLTAGE_BLANKING_US   = 30;
	localparam int unsigned OVERCURRENT_QUALIFY_DELAY_MS = 25;
	localparam int unsigned RESTART_TIME_S            = 1;

	// Interval counts in cycles
	localparam int unsigned OVERVOLTAGE_BLANKING_CYC =
		OVERVOLTAGE_BLANKING_US * (CLK_HZ / 1_000_000);
	localparam int unsigned OVERCURRENT_QUALIFY_DELAY_CYC =
		OVERCURRENT_QUALIFY_DELAY_MS * (CLK_HZ / 1_000);
	localparam int unsigned RESTART_TIME_CYC = RESTART_TIME_S * CLK_HZ;

	// Fault indices
	localparam int unsigned FAULT_COUNT = 5;
	localparam int unsigned F_LOCKOUT   = 0;
	localparam int unsigned F_OVERVOLT  = 1;
	localparam int unsigned F_UNDERVOLT = 2;
	localparam int unsigned F_OVERCUR   = 3;
	localparam int unsigned F_OVERTEMP  = 4;

	// Reset values
	localparam logic [FAULT_COUNT-1:0] FAULT_CAUSE_RESET = 5'h00;
	localparam logic [31:0]            TIMER_RESET       = 32'h00000000;

	// Profiles without undervoltage guard: default_5v_profile and second_profile
	localparam logic [2:0] DEFAULT_5V_PROFILE = 3'h0;
	localparam logic [2:0] SECOND_PROFILE     = 3'h1;

	// Sequencer states, Gray along lockout, start-up, run, restart, latch
	typedef enum logic [2:0] {
		ST_LOCKOUT = 3'h0,
		ST_STARTUP = 3'h1,
		ST_RUN     = 3'h3,
		ST_RESTART = 3'h2,
		ST_LATCHED = 3'h6
	} pfs_state_t;

	// Synchronous comparator and sensor levels
	typedef struct packed {
		logic supply_above_rise;
		logic supply_below_fall;
		logic overvoltage;
		logic undervoltage;
		logic over_current_limit;
		logic over_temp;
		logic supply_lost;
	} pfs_sense_t;

	// Drive towards the power stage and the coupler
	typedef struct packed {
		logic load_switch;
		logic current_sink;
		logic coupler_zero;
		logic coupler_hold;
		logic regulate_safe5v;
		logic profile_default;
		logic regulate_profile;
	} pfs_drive_t;

endpackage
`default_nettype wire

// *** hdl/pfs_qualifier.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfs_qualifier
	import pfs_pkg::*;
#(
	parameter int unsigned DELAY = 0
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic cond,
	output logic      qualified
);

	generate
		if (DELAY == 0) begin : g_direct
			// No qualifying delay: pass at once
			assign qualified = cond;
		end else begin : g_timed
			logic [31:0] count;
			logic        hit;
			wire         at_end = (count == 32'(DELAY - 1));

			// Count while the condition stands, clear when it drops
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					count <= TIMER_RESET;
					hit   <= 1'b0;
				end else if (!cond) begin
					count <= TIMER_RESET;
					hit   <= 1'b0;
				end else if (at_end) begin
					hit <= 1'b1;
				end else if (!hit) begin
					count <= count + 32'h00000001;
				end
			end

			assign qualified = hit & cond;
		end
	endgenerate

endmodule
`default_nettype wire

// *** verif/pfs_sequencer_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfs_checker
	import pfs_pkg::*;
#(
	parameter int unsigned OCP_CYC = 50,
	parameter int unsigned RST_CYC = 100
) (
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire pfs_sense_t             sense,
	input  wire logic                   contract_done,
	input  wire pfs_drive_t             drive,
	input  wire pfs_state_t             seq_state,
	input  wire logic [FAULT_COUNT-1:0] fault_cause
);
	int unsigned ov_cnt;
	int unsigned oc_cnt;
	int unsigned rs_cnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Run lengths of the timed conditions
	always_ff @(posedge mclk) begin
		ov_cnt <= sense.overvoltage ? ov_cnt + 1 : 0;
		oc_cnt <= sense.over_current_limit ? oc_cnt + 1 : 0;
		rs_cnt <= (seq_state == ST_RESTART && sense.supply_above_rise) ? rs_cnt + 1 : 0;
	end
	lock_cut_a: assert property (sense.supply_below_fall |-> !drive.load_switch)
		else $error("switch closed under lockout");
	loss_cut_a: assert property (sense.supply_lost |-> !drive.load_switch)
		else $error("switch closed on supply loss");
	latch_drive_a: assert property (seq_state == ST_LATCHED |-> drive.current_sink && drive.coupler_zero && !drive.load_switch)
		else $error("latched drive wrong");
	latch_stay_a: assert property (seq_state == ST_LATCHED |=> seq_state == ST_LATCHED)
		else $error("latched state left");
	heat_latch_a: assert property (seq_state inside {ST_STARTUP, ST_RUN} && sense.over_temp |=> seq_state == ST_LATCHED)
		else $error("overtemperature not latched");
	restart_safe_a: assert property (seq_state == ST_RESTART |-> !drive.load_switch && drive.profile_default)
		else $error("restart drive wrong");
	restart_time_a: assert property (seq_state == ST_RESTART ##1 seq_state == ST_STARTUP |-> rs_cnt + 1 >= RST_CYC && rs_cnt <= RST_CYC + 1)
		else $error("restart time wrong");
	restart_bound_a: assert property (rs_cnt <= RST_CYC + 1)
		else $error("restart never ends");
	run_gate_a: assert property (seq_state == ST_STARTUP && !contract_done |=> seq_state != ST_RUN)
		else $error("run before contract");
	ov_blank_a: assert property ($rose(fault_cause[F_OVERVOLT]) |-> ov_cnt >= OVERVOLTAGE_BLANKING_CYC)
		else $error("overvoltage trip too early");
	oc_delay_a: assert property ($rose(fault_cause[F_OVERCUR]) |-> oc_cnt >= OCP_CYC)
		else $error("overcurrent trip too early");
endmodule
`default_nettype wire

// *** verif/pfs_primary.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfs_primary #(
	parameter int unsigned STOP_CYC = 40,
	parameter int unsigned BACK_CYC = 60
) (
	input  wire logic mclk,
	input  wire logic coupler_zero,
	output logic      supply_up
);
	int unsigned cnt = 0;
	// Zero coupler current: power climbs, primary trips, then restarts
	always_ff @(posedge mclk) begin
		cnt <= coupler_zero ? (cnt == BACK_CYC ? 0 : cnt + 1) : 0;
	end
	assign supply_up = cnt < STOP_CYC;
endmodule
`default_nettype wire

// *** verif/pfs_sequencer_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module pfs_sequencer_bench
	import pfs_pkg::*;
;
	localparam int unsigned OVERCURRENT_GUARD = 50;
	localparam int unsigned RST = 100;
	logic                   mclk = 1'b0;
	logic                   reset_n = 1'b0;
	pfs_sense_t             s = 7'h40;
	pfs_sense_t             sense;
	logic [FAULT_COUNT-1:0] cfg = 5'h00;
	logic                   var_cc = 1'b0;
	logic [2:0]             prof = 3'h0;
	logic                   done = 1'b1;
	pfs_drive_t             drive;
	logic                   ccr;
	pfs_state_t             seq_state;
	logic                   pri_up;
	logic [FAULT_COUNT-1:0] cause;
	int                     failures = 0;
	int                     n_tests = 0;
	// Sense, latch choice, profile, resulting state
	logic [17:0]            rows [6] = '{18'h10002, 18'h10046, 18'h24012, 18'h2400B, 18'h21006, 18'h24126};
	always #5 mclk = ~mclk;
	// Primary side model sets the supply level
	assign sense = s & {pri_up, 6'h3F} | {1'b0, ~pri_up, 5'h00};
	pfs_primary pri (
		.mclk        (mclk),
		.coupler_zero(drive.coupler_zero),
		.supply_up   (pri_up)
	);
	pfs_sequencer #(
		.OVERCURRENT_QUALIFY_CYC(OVERCURRENT_GUARD),
		.RESTART_CYC            (RST)
	) dut (
		.mclk                       (mclk),
		.reset_n                    (reset_n),
		.sense                      (sense),
		.fault_latch_cfg            (cfg),
		.variant_constant_current   (var_cc),
		.profile_index              (prof),
		.contract_done              (done),
		.drive                      (drive),
		.constant_current_regulation(ccr),
		.seq_state                  (seq_state),
		.fault_cause                (cause)
	);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Advance n edges, settle at the falling edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic wait_st(input pfs_state_t st, input int lim);
		for (int i = 0; i < lim && seq_state !== st; i++)
			tick(0);
		check(seq_state, st);
	endtask
	// Reset, then bring the sequencer into regulation
	task automatic boot(input logic [2:0] p);
		@(posedge mclk) reset_n <= 1'b0;
		s <= 7'h40;
		cfg <= 5'h00;
		var_cc <= 1'b0;
		prof <= p;
		done <= 1'b1;
		tick(20);
		check({drive, seq_state}, 10'h000);
		@(posedge mclk) reset_n <= 1'b1;
		wait_st(ST_RUN, 10);
	endtask
	initial begin
		foreach (rows[k]) begin
			boot(rows[k][5:3]);
			@(posedge mclk) s <= rows[k][17:11];
			cfg <= rows[k][10:6];
			tick(3);
			check(seq_state, rows[k][2:0]);
			check(drive.coupler_zero, rows[k][2:0] == ST_LATCHED);
		end
		// Overcurrent: a short burst is forgotten, a long one restarts
		boot(3'h2);
		@(posedge mclk) s.over_current_limit <= 1'b1;
		done <= 1'b0;
		tick(OVERCURRENT_GUARD / 2);
		@(posedge mclk) s.over_current_limit <= 1'b0;
		tick(2);
		@(posedge mclk) s.over_current_limit <= 1'b1;
		tick(OVERCURRENT_GUARD - 5);
		check(seq_state, ST_RUN);
		wait_st(ST_RESTART, 10);
		check(cause, 5'h08);
		check({drive.load_switch, drive.regulate_safe5v, drive.profile_default}, 3'h3);
		@(posedge mclk) s.over_current_limit <= 1'b0;
		tick(RST - 10);
		check(seq_state, ST_RESTART);
		wait_st(ST_STARTUP, 20);
		check(drive.load_switch, 1'b1);
		tick(10);
		check({drive.regulate_profile, seq_state}, {1'b0, ST_STARTUP});
		@(posedge mclk) done <= 1'b1;
		wait_st(ST_RUN, 5);
		@(posedge mclk) s.over_current_limit <= 1'b1;
		wait_st(ST_RESTART, OVERCURRENT_GUARD + 10);
		// Overvoltage must outlast its blanking time
		boot(3'h0);
		@(posedge mclk) s.overvoltage <= 1'b1;
		tick(OVERVOLTAGE_BLANKING_CYC - 10);
		check(seq_state, ST_RUN);
		wait_st(ST_RESTART, 20);
		check(cause, 5'h02);
		// Constant-current variant, then a supply loss
		boot(3'h3);
		@(posedge mclk) var_cc <= 1'b1;
		s.over_current_limit <= 1'b1;
		tick(OVERCURRENT_GUARD + 10);
		check({drive.coupler_hold, ccr, seq_state}, {2'h3, ST_RUN});
		@(posedge mclk) s.supply_lost <= 1'b1;
		tick(0);
		check(drive.load_switch, 1'b0);
		@(posedge mclk) s.supply_lost <= 1'b0;
		tick(0);
		check({drive.load_switch, seq_state}, {1'b1, ST_RUN});
		// Latched overvoltage while the primary cycles the supply
		boot(3'h0);
		@(posedge mclk) cfg <= 5'h02;
		s.overvoltage <= 1'b1;
		wait_st(ST_LATCHED, OVERVOLTAGE_BLANKING_CYC + 20);
		tick(150);
		check({drive.load_switch, drive.coupler_zero, seq_state}, {2'h1, ST_LATCHED});
		results();
	end
	// Watchdog
	initial begin
		#200000;
		failures++;
		results();
	end
endmodule
bind pfs_sequencer pfs_checker #(
	.OCP_CYC(OVERCURRENT_QUALIFY_CYC),
	.RST_CYC(RESTART_CYC)
) chk (
	.mclk         (mclk),
	.reset_n      (reset_n),
	.sense        (sense),
	.contract_done(contract_done),
	.drive        (drive),
	.seq_state    (seq_state),
	.fault_cause  (fault_cause)
);
`default_nettype wire
